// file: core/sgpc_pkg.sv
// ****************************************************************
// package: register map, field layout and timing of the pin block
// ****************************************************************
package sgpc_pkg;
   // register addresses
   localparam logic [7:0] SGPC_CID_ADDR = 8'h11;
   localparam logic [7:0] SGPC_CFG_ADDR = 8'h12;
   // configuration register field positions
   localparam int SGPC_DIR_BIT = 0;
   localparam int SGPC_RDBK_BIT = 1;
   localparam int SGPC_DRV_BIT = 2;
   localparam int SGPC_LVL_BIT = 3;
   localparam int SGPC_DBEN_BIT = 4;
   // identity register field positions
   localparam int SGPC_IDENT_LSB = 0;
   localparam int SGPC_DIV_LSB = 4;
   // field widths
   localparam int SGPC_IDENT_W = 4;
   localparam int SGPC_DIV_W = 3;
   // reset values of the configuration fields
   localparam logic SGPC_DIR_RST = 1'h1;
   localparam logic SGPC_DRV_RST = 1'h0;
   localparam logic SGPC_LVL_RST = 1'h0;
   localparam logic SGPC_DBEN_RST = 1'h0;
   // direction and driver encodings
   localparam logic SGPC_DIR_OUT = 1'h0;
   localparam logic SGPC_DRV_OPEN = 1'h0;
   // divider codes: fastest code; each code above it is one step slower
   localparam logic [2:0] SGPC_DIV_FAST = 3'h3;
   // timing
   localparam longint unsigned SGPC_CLK_HZ = 250000000;
   localparam longint unsigned SGPC_DBC_MS = 30;
   localparam longint unsigned SGPC_FAST_HZ = 160;
   localparam longint unsigned SGPC_DBC_CYC = SGPC_DBC_MS * SGPC_CLK_HZ / 1000;
   localparam longint unsigned SGPC_FAST_CYC = SGPC_CLK_HZ / SGPC_FAST_HZ;
endpackage : sgpc_pkg

// file: core/sgpc_dbc_if.sv
`timescale 1ns/1ps
// ****************************************************************
// carrier between the pin logic and its input filter
// ****************************************************************
interface sgpc_dbc_if;
   logic raw;
   logic en;
   logic level;
   modport filt (input raw, input en, output level);
   modport user (output raw, output en, input level);
endinterface : sgpc_dbc_if

// file: core/sgpc_debounce.sv
`timescale 1ns/1ps
// ****************************************************************
// input filter: level accepted after it holds steady long enough
// ****************************************************************
module sgpc_debounce #(
   parameter int unsigned CYCLES = 7500000
) (
   input wire logic ref_clk,
   input wire logic nrst,
   sgpc_dbc_if.filt dbc
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic level_r;
   logic [CW-1:0] cnt_r;

   assign dbc.level = level_r;

   // steady-time counter, restarts whenever input matches accepted level
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
      end else if (!dbc.en || dbc.raw == level_r || cnt_r == LAST) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + CW'(1);
      end
   end

   // accepted level: direct when filter off, after full hold when on
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         level_r <= 1'h0;
      end else if (!dbc.en) begin
         level_r <= dbc.raw;
      end else if (dbc.raw != level_r && cnt_r == LAST) begin
         level_r <= dbc.raw;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   bypass_pass_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !dbc.en |=> level_r == $past(dbc.raw))
      else $error("filter off but level not passed through");
   hold_level_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      dbc.en && cnt_r == '0 && dbc.raw != level_r |=> $stable(level_r))
      else $error("level accepted before hold time");
   accept_cv: cover property (@(posedge ref_clk) disable iff (!nrst)
      dbc.en && $changed(level_r));
endmodule : sgpc_debounce

// file: core/sgpc_top.sv
`timescale 1ns/1ps
// Contract
// - direction bit: 0 output, 1 input
// - drive style: 0 open-drain, 1 push-pull
// - output low level always drives low
// - high level: push-pull drives, open-drain floats
// - input mode ignores level and drive style
// - readback bit always shows pin level
// - optional 30 ms input debounce
// - divider code sets sampling tick rate
// - identity code reports programmed configuration
// - latch edges, unmasked ones pull interrupt low
module sgpc_top
   import sgpc_pkg::*;
#(
   parameter int unsigned DBC_CYCLES = int'(SGPC_DBC_CYC),
   parameter int unsigned FAST_CYCLES = int'(SGPC_FAST_CYC)
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic system_reset_event,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic gpio_in,
   output logic gpio_out,
   output logic gpio_oe,
   input wire logic [SGPC_IDENT_W-1:0] otp_chip_ident,
   input wire logic [SGPC_DIV_W-1:0] otp_sample_div,
   output logic sample_tick,
   input wire logic rise_mask,
   input wire logic fall_mask,
   input wire logic event_clear,
   output logic input_rise_event,
   output logic input_fall_event,
   output logic interrupt_out_n
);
   // ****************************************************************
   // state
   // ****************************************************************
   logic cfg_dir_r, cfg_drv_r, cfg_lvl_r, cfg_dben_r;
   logic pin_s_r, lvl_prev_r, edge_armed_r;
   logic [1:0] arm_sr_r;
   logic gpio_out_r, gpio_oe_r;
   logic [7:0] rdata_r;
   logic [SGPC_IDENT_W-1:0] ident_r;
   logic [SGPC_DIV_W-1:0] div_r;
   logic ident_loaded_r;
   logic [31:0] tick_cnt_r, tick_len;
   logic tick_r;
   logic rise_r, fall_r, irq_n_r;
   logic rise_evt, fall_evt;

   sgpc_dbc_if dbc ();

   // decode of a register access to one address
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
      hit = (a == ref_a);
   endfunction : hit

   assign reg_rdata = rdata_r;
   assign gpio_out = gpio_out_r;
   assign gpio_oe = gpio_oe_r;
   assign sample_tick = tick_r;
   assign input_rise_event = rise_r;
   assign input_fall_event = fall_r;
   assign interrupt_out_n = irq_n_r;

   // ****************************************************************
   // configuration register
   // ****************************************************************
   // system reset first, then host writes; only defined bits are kept
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cfg_dir_r <= SGPC_DIR_RST;
         cfg_drv_r <= SGPC_DRV_RST;
         cfg_lvl_r <= SGPC_LVL_RST;
         cfg_dben_r <= SGPC_DBEN_RST;
      end else if (system_reset_event) begin
         cfg_dir_r <= SGPC_DIR_RST;
         cfg_drv_r <= SGPC_DRV_RST;
         cfg_lvl_r <= SGPC_LVL_RST;
         cfg_dben_r <= SGPC_DBEN_RST;
      end else if (reg_wr && hit(reg_addr, SGPC_CFG_ADDR)) begin
         cfg_dir_r <= reg_wdata[SGPC_DIR_BIT];
         cfg_drv_r <= reg_wdata[SGPC_DRV_BIT];
         cfg_lvl_r <= reg_wdata[SGPC_LVL_BIT];
         cfg_dben_r <= reg_wdata[SGPC_DBEN_BIT];
      end
   end

   // ****************************************************************
   // pin driver
   // ****************************************************************
   // enable only in output mode; open-drain never drives high
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         gpio_oe_r <= 1'h0;
         gpio_out_r <= 1'h0;
      end else if (cfg_dir_r != SGPC_DIR_OUT) begin
         gpio_oe_r <= 1'h0;
         gpio_out_r <= 1'h0;
      end else if (!cfg_lvl_r) begin
         gpio_oe_r <= 1'h1;
         gpio_out_r <= 1'h0;
      end else begin
         gpio_oe_r <= (cfg_drv_r != SGPC_DRV_OPEN);
         gpio_out_r <= (cfg_drv_r != SGPC_DRV_OPEN);
      end
   end

   // ****************************************************************
   // input path and edge events
   // ****************************************************************
   // pin sample, used for readback and the filter
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pin_s_r <= 1'h0;
      end else begin
         pin_s_r <= gpio_in;
      end
   end

   assign dbc.raw = pin_s_r;
   assign dbc.en = cfg_dben_r;

   sgpc_debounce #(.CYCLES(DBC_CYCLES)) u_dbc (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .dbc(dbc)
   );

   // previous filtered level; edges armed only once sample, level and
   // previous level all hold real pin values, so a pin idling high after
   // reset is not taken for a rising edge
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         lvl_prev_r <= 1'h0;
         arm_sr_r <= '0;
         edge_armed_r <= 1'h0;
      end else begin
         lvl_prev_r <= dbc.level;
         arm_sr_r <= {arm_sr_r[0], 1'h1};
         edge_armed_r <= arm_sr_r[1];
      end
   end

   assign rise_evt = edge_armed_r && dbc.level && !lvl_prev_r;
   assign fall_evt = edge_armed_r && !dbc.level && lvl_prev_r;

   // sticky flags; a new edge wins over a clear in the same cycle
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rise_r <= 1'h0;
         fall_r <= 1'h0;
      end else if (system_reset_event) begin
         rise_r <= 1'h0;
         fall_r <= 1'h0;
      end else begin
         rise_r <= rise_evt || (rise_r && !event_clear);
         fall_r <= fall_evt || (fall_r && !event_clear);
      end
   end

   // interrupt output low while any unmasked flag stands
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         irq_n_r <= 1'h1;
      end else begin
         irq_n_r <= !((rise_r && !rise_mask) || (fall_r && !fall_mask));
      end
   end

   // ****************************************************************
   // identity register and sampling clock
   // ****************************************************************
   // programmed values caught once after power-on release
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ident_r <= '0;
         div_r <= '0;
         ident_loaded_r <= 1'h0;
      end else if (!ident_loaded_r) begin
         ident_r <= otp_chip_ident;
         div_r <= otp_sample_div;
         ident_loaded_r <= 1'h1;
      end
   end

   // tick period doubles per code step above the fastest code
   always_comb begin
      if (div_r > SGPC_DIV_FAST) begin
         tick_len = FAST_CYCLES << (div_r - SGPC_DIV_FAST);
      end else begin
         tick_len = FAST_CYCLES;
      end
   end

   // sampling tick, one cycle wide, once per period
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tick_cnt_r <= '0;
         tick_r <= 1'h0;
      end else if (!ident_loaded_r || tick_cnt_r >= tick_len - 32'h1) begin
         tick_cnt_r <= '0;
         tick_r <= ident_loaded_r;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h1;
         tick_r <= 1'h0;
      end
   end

   // ****************************************************************
   // register read
   // ****************************************************************
   // read data one cycle after the strobe; unused bits read zero
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_r <= '0;
      end else if (reg_rd && hit(reg_addr, SGPC_CFG_ADDR)) begin
         rdata_r <= '0;
         rdata_r[SGPC_DIR_BIT] <= cfg_dir_r;
         rdata_r[SGPC_RDBK_BIT] <= pin_s_r;
         rdata_r[SGPC_DRV_BIT] <= cfg_drv_r;
         rdata_r[SGPC_LVL_BIT] <= cfg_lvl_r;
         rdata_r[SGPC_DBEN_BIT] <= cfg_dben_r;
      end else if (reg_rd && hit(reg_addr, SGPC_CID_ADDR)) begin
         rdata_r <= '0;
         rdata_r[SGPC_IDENT_LSB +: SGPC_IDENT_W] <= ident_r;
         rdata_r[SGPC_DIV_LSB +: SGPC_DIV_W] <= div_r;
      end else if (reg_rd) begin
         rdata_r <= '0;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   input_float_a: assert property (cfg_dir_r |=> !gpio_oe_r)
      else $error("pin driven in input mode");
   low_drive_a: assert property (!cfg_dir_r && !cfg_lvl_r |=> gpio_oe_r && !gpio_out_r)
      else $error("output low not driven low");
   pp_high_a: assert property (!cfg_dir_r && cfg_lvl_r && cfg_drv_r
      |=> gpio_oe_r && gpio_out_r)
      else $error("push-pull high not driven");
   od_float_a: assert property (!cfg_dir_r && cfg_lvl_r && !cfg_drv_r |=> !gpio_oe_r)
      else $error("open-drain high driven");
   readback_a: assert property (reg_rd && reg_addr == SGPC_CFG_ADDR
      |=> reg_rdata[SGPC_RDBK_BIT] == $past(pin_s_r))
      else $error("readback bit not pin level");
   ident_read_a: assert property (reg_rd && reg_addr == SGPC_CID_ADDR && ident_loaded_r
      |=> reg_rdata[SGPC_IDENT_LSB +: SGPC_IDENT_W] == ident_r)
      else $error("identity code mismatch");
   sys_reset_a: assert property (system_reset_event
      |=> cfg_dir_r && !cfg_dben_r && !cfg_lvl_r && !cfg_drv_r)
      else $error("default configuration not restored");
   rise_latch_a: assert property (rise_evt && !system_reset_event
      |=> rise_r ##1 ($past(rise_mask) || !irq_n_r))
      else $error("rising edge lost or interrupt missing");
   mask_quiet_a: assert property (rise_mask && fall_mask |=> irq_n_r)
      else $error("interrupt with all events masked");
   raw_edge_a: assert property (edge_armed_r && !cfg_dben_r && $past(!cfg_dben_r) && pin_s_r
      && !$past(pin_s_r) |=> rise_evt)
      else $error("raw edge not seen");
   tick_once_a: assert property (tick_r |=> !tick_r)
      else $error("sampling tick wider than one cycle");

   out_mode_cv: cover property (!cfg_dir_r && cfg_lvl_r && cfg_drv_r ##1 gpio_oe_r);
   irq_cv: cover property (!irq_n_r ##1 event_clear ##2 irq_n_r);
   dbc_edge_cv: cover property (cfg_dben_r && rise_evt);
   tick_cv: cover property (tick_r);
endmodule : sgpc_top

// file: bench/sgpc_host.sv
`timescale 1ns/1ps
// ****************************************************************
// host model: byte strobe register access
// ****************************************************************
module sgpc_host (
   input wire logic ref_clk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   // idle bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // one access held over one rising edge, then the bus is inverted
   task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : acc
endmodule : sgpc_host

// file: bench/single_pin_gpio_config_tb_top.sv
`timescale 1ns/1ps
// ****************************************************************
// bench: pin block against host model and pad
// ****************************************************************
module single_pin_gpio_config_tb_top;
   import sgpc_pkg::*;
   logic ref_clk, nrst, system_reset_event, reg_wr, reg_rd, ext, sample_tick;
   logic gpio_out, gpio_oe, rise_mask, fall_mask, event_clear;
   logic input_rise_event, input_fall_event, interrupt_out_n, eoe, eout;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, c;
   logic [3:0] otp_id;
   logic [2:0] otp_div;
   logic [31:0] s;
   logic [7:0] exp_q[$];
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   // pad: driven level wins, otherwise the outside level
   wire pin = gpio_oe ? gpio_out : ext;
   sgpc_host h (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd));
   sgpc_top #(.DBC_CYCLES(8), .FAST_CYCLES(4)) i_dut (.ref_clk(ref_clk), .nrst(nrst),
      .system_reset_event(system_reset_event), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_in(pin),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .otp_chip_ident(otp_id),
      .otp_sample_div(otp_div), .sample_tick(sample_tick), .rise_mask(rise_mask),
      .fall_mask(fall_mask), .event_clear(event_clear), .input_rise_event(input_rise_event),
      .input_fall_event(input_fall_event), .interrupt_out_n(interrupt_out_n));
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim();
      if (failures == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      exp_q.push_back(exp);
      h.acc(a, 8'h00, 1'b0);
   endtask : rd
   task automatic ev_chk(input logic r, input logic f, input logic irq);
      check(8'(input_rise_event), 8'(r));
      check(8'(input_fall_event), 8'(f));
      check(8'(interrupt_out_n), 8'(irq));
   endtask : ev_chk
   task automatic tick_chk(input int per);
      int n;
      n = 0;
      while (sample_tick !== 1'b1 && n < 300) begin
         cyc(1);
         n++;
      end
      n = 0;
      cyc(1);
      while (sample_tick !== 1'b1 && n < 300) begin
         cyc(1);
         n++;
      end
      check(8'(n + 1), 8'(per));
   endtask : tick_chk
   // clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // read results are compared against the oldest note
   always @(posedge ref_clk) begin
      if (reg_rd === 1'b1) begin
         @(negedge ref_clk);
         check(reg_rdata, exp_q.pop_front());
      end
   end
   // hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end
   // main sequence
   initial begin
      s = lfsr(32'h0975);
      {otp_div, otp_id} = s[6:0];
      nrst = 1'b0;
      system_reset_event = 1'b0;
      ext = 1'b1;
      rise_mask = 1'b0;
      fall_mask = 1'b0;
      event_clear = 1'b0;
      cyc(12);
      nrst = 1'b1;
      rd(SGPC_CFG_ADDR, 8'h03);
      h.acc(SGPC_CID_ADDR, 8'h0F, 1'b1);
      rd(SGPC_CID_ADDR, {1'b0, otp_div, otp_id});
      rd(8'h13, 8'h00);
      ev_chk(1'b0, 1'b0, 1'b1);
      tick_chk(4 << (otp_div > 3'h3 ? otp_div - 3'h3 : 0));
      // every direction, driver and level combination
      for (int m = 0; m < 8; m++) begin
         s = lfsr(s);
         ext = s[0];
         c = {4'h0, m[2], m[1], 1'b0, m[0]};
         h.acc(SGPC_CFG_ADDR, c, 1'b1);
         cyc(2);
         eoe = !m[0] & (!m[2] | m[1]);
         eout = !m[0] & m[2] & m[1];
         check(8'(gpio_oe), 8'(eoe));
         check(8'(gpio_out), 8'(eout));
         rd(SGPC_CFG_ADDR, c | {6'h0, (eoe ? eout : ext), 1'b0});
      end
      // edge events without debounce
      h.acc(SGPC_CFG_ADDR, 8'h01, 1'b1);
      ext = 1'b0;
      cyc(6);
      event_clear = 1'b1;
      cyc(1);
      event_clear = 1'b0;
      cyc(2);
      ev_chk(1'b0, 1'b0, 1'b1);
      ext = 1'b1;
      cyc(6);
      ev_chk(1'b1, 1'b0, 1'b0);
      rise_mask = 1'b1;
      cyc(3);
      ev_chk(1'b1, 1'b0, 1'b1);
      event_clear = 1'b1;
      cyc(1);
      event_clear = 1'b0;
      cyc(2);
      ev_chk(1'b0, 1'b0, 1'b1);
      ext = 1'b0;
      cyc(6);
      ev_chk(1'b0, 1'b1, 1'b0);
      // system reset restores defaults and drops flags
      system_reset_event = 1'b1;
      cyc(1);
      system_reset_event = 1'b0;
      cyc(2);
      ev_chk(1'b0, 1'b0, 1'b1);
      rd(SGPC_CFG_ADDR, 8'h01);
      // debounce: short glitch ignored, steady level accepted
      h.acc(SGPC_CFG_ADDR, 8'h11, 1'b1);
      rd(SGPC_CFG_ADDR, 8'h11);
      ext = 1'b1;
      cyc(4);
      ext = 1'b0;
      cyc(12);
      ev_chk(1'b0, 1'b0, 1'b1);
      ext = 1'b1;
      cyc(14);
      ev_chk(1'b1, 1'b0, 1'b1);
      // both edges masked: falling flag latches, interrupt stays high
      fall_mask = 1'b1;
      ext = 1'b0;
      cyc(14);
      ev_chk(1'b1, 1'b1, 1'b1);
      cyc(2);
      end_sim();
   end
endmodule : single_pin_gpio_config_tb_top
